// ---- core/drc_map.svh ----
/*
 Constants for the DRAM and slot bus refresh controller.
 Assumes inclusion by the refresh controller and its bench; holds definitions.
*/
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define DRC_REG_CTRL 4'h0
`define DRC_REG_STAT 4'h4
`define DRC_REG_SLOTDIV 4'h8

// --------------------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------------------
`define DRC_CTRL_MODE_LO 0
`define DRC_CTRL_CBR 2
`define DRC_CTRL_SLOW 3
`define DRC_CTRL_EN 4
`define DRC_CTRL_RESET 8'h10
`define DRC_SLOTDIV_RESET 16'h061A

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define DRC_CLK_PERIOD_PS 10000
`define DRC_T_STD_PS 15625000
`define DRC_T_SLOW_PS 125000000
`define DRC_STD_CYC (`DRC_T_STD_PS / `DRC_CLK_PERIOD_PS)
`define DRC_SLOW_CYC (`DRC_T_SLOW_PS / `DRC_CLK_PERIOD_PS)
`define DRC_STAGGER_CYC 2
`define DRC_RAS_CYC 6
`define DRC_SLOT_CYC 20
`define DRC_BANKS 4

`endif

// ---- core/drc_pkg.sv ----
/*
 Types for the DRAM and slot bus refresh controller.
 Assumes nothing of its surroundings.
*/
package drc_pkg;

   typedef enum logic [1:0]
   {
      DRC_MODE_SYNC = 2'b00,
      DRC_MODE_ASYNC = 2'b01,
      DRC_MODE_DECOUP = 2'b10,
      DRC_MODE_RSVD = 2'b11
   } drc_mode_e;

   typedef enum logic [1:0]
   {
      DRC_IDLE = 2'b00,
      DRC_WAIT = 2'b01,
      DRC_RUN = 2'b10
   } drc_state_e;

   typedef struct packed
   {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } drc_bus_s;

   typedef struct packed
   {
      logic [3:0] ras_n;
      logic cas_n;
   } drc_dram_s;

endpackage

// ---- core/drc_refresh.sv ----
/*
 Refresh controller: on-board DRAM refresh and slot bus refresh timing.
 Assumes a 100 MHz clock, synchronous inputs and a plain register port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "drc_map.svh"

module drc_refresh
   import drc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire drc_bus_s i_bus,
   output logic [15:0] o_rdata,
   input wire logic i_mem_busy,
   input wire logic i_mem_req,
   output logic o_mem_hold,
   output drc_dram_s o_dram,
   output logic o_slot_refresh_n,
   output logic o_slot_active
);

   // -----------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------
   logic [7:0] ctrl;
   logic [15:0] slot_div;
   drc_mode_e mode;
   logic cbr_en;
   logic slow;
   logic enable;
   assign mode = drc_mode_e'(ctrl[`DRC_CTRL_MODE_LO +: 2]);
   assign cbr_en = ctrl[`DRC_CTRL_CBR];
   assign slow = ctrl[`DRC_CTRL_SLOW];
   assign enable = ctrl[`DRC_CTRL_EN];

   drc_state_e state;
   logic dram_pend;
   logic slot_pend;
   logic [3:0] slot_cnt;

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ctrl <= `DRC_CTRL_RESET;
         slot_div <= `DRC_SLOTDIV_RESET;
      end
      else if (i_bus.wr && i_bus.addr == `DRC_REG_CTRL)
         ctrl <= i_bus.wdata[7:0];
      else if (i_bus.wr && i_bus.addr == `DRC_REG_SLOTDIV)
         slot_div <= i_bus.wdata;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_rdata <= 16'h0000;
      else if (i_bus.rd)
      begin
         unique case (i_bus.addr)
            `DRC_REG_CTRL: o_rdata <= {8'h00, ctrl};
            `DRC_REG_STAT: o_rdata <= {11'h000, dram_pend, slot_pend, o_slot_active,
                                       state};
            `DRC_REG_SLOTDIV: o_rdata <= slot_div;
            default: o_rdata <= 16'h0000;
         endcase
      end
      else
         o_rdata <= 16'h0000;
   end

   // -----------------------------------------------------------------------
   // Interval timers
   // -----------------------------------------------------------------------
   logic [13:0] tick_cnt;
   logic tick;
   logic [13:0] tick_max;
   assign tick_max = slow ? 14'(`DRC_SLOW_CYC - 1) : 14'(`DRC_STD_CYC - 1);
   assign tick = enable && tick_cnt == 14'h0000;

   always_ff @(posedge i_clk)
   begin
      if (i_reset || !enable)
         tick_cnt <= 14'(`DRC_STD_CYC - 1);
      else if (tick_cnt == 14'h0000)
         tick_cnt <= tick_max;
      else
         tick_cnt <= tick_cnt - 14'h0001;
   end

   // Decoupled mode paces the slot bus from its own divider.
   logic [15:0] slot_tmr;
   logic slot_tick;
   assign slot_tick = enable && slot_tmr == 16'h0000;

   always_ff @(posedge i_clk)
   begin
      if (i_reset || !enable || mode != DRC_MODE_DECOUP)
         slot_tmr <= slot_div;
      else if (slot_tmr == 16'h0000)
         slot_tmr <= slot_div;
      else
         slot_tmr <= slot_tmr - 16'h0001;
   end

   // -----------------------------------------------------------------------
   // Pending requests
   // -----------------------------------------------------------------------
   logic dram_start;
   logic slot_start;
   logic can_start;
   logic [3:0] ras_cnt;
   logic dram_done;
   assign dram_done = state == DRC_RUN && ras_cnt == 4'(`DRC_RAS_CYC - 1);

   // Decoupled DRAM refresh waits for a cycle with no memory request.
   assign can_start = !i_mem_busy && !(mode == DRC_MODE_DECOUP && i_mem_req);
   assign dram_start = state == DRC_WAIT && can_start;
   assign slot_start = slot_pend && !o_slot_active
      && (mode == DRC_MODE_DECOUP || dram_start);

   // A new tick wins over the clear of the same pending flag.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         dram_pend <= 1'b0;
      else if (tick)
         dram_pend <= 1'b1;
      else if (dram_start)
         dram_pend <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         slot_pend <= 1'b0;
      else if (mode == DRC_MODE_DECOUP ? slot_tick : tick)
         slot_pend <= 1'b1;
      else if (slot_start)
         slot_pend <= 1'b0;
   end

   // -----------------------------------------------------------------------
   // On-board refresh sequencer
   // -----------------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         state <= DRC_IDLE;
      else
      begin
         unique case (state)
            DRC_IDLE: if (dram_pend) state <= DRC_WAIT;
            DRC_WAIT: if (can_start) state <= DRC_RUN;
            DRC_RUN: if (dram_done) state <= DRC_IDLE;
            default: state <= DRC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset || state != DRC_RUN)
         ras_cnt <= 4'h0;
      else
         ras_cnt <= ras_cnt + 4'h1;
   end

   // Bank b asserts its row strobe b clock cycles after the start, half a stagger step per bank.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_dram <= '1;
      else
      begin
         for (int b = 0; b < `DRC_BANKS; b++)
            o_dram.ras_n[b] <= !(state == DRC_RUN && !dram_done
               && ras_cnt >= 4'(b * `DRC_STAGGER_CYC / 2));
         o_dram.cas_n <= !(cbr_en && state == DRC_WAIT && can_start)
            && !(cbr_en && state == DRC_RUN && !dram_done);
      end
   end

   // -----------------------------------------------------------------------
   // Slot bus refresh timing
   // -----------------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         slot_cnt <= 4'h0;
      else if (slot_start)
         slot_cnt <= 4'hF;
      else if (slot_cnt != 4'h0)
         slot_cnt <= slot_cnt - 4'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_slot_active <= 1'b0;
         o_slot_refresh_n <= 1'b1;
      end
      else
      begin
         o_slot_active <= slot_start || slot_cnt > 4'h1;
         o_slot_refresh_n <= !(slot_start || slot_cnt > 4'h1);
      end
   end

   // Sync mode holds memory for both refreshes; the other modes hold only
   // for the on-board refresh, so the slot refresh stays hidden.
   assign o_mem_hold = state == DRC_RUN
      || (mode == DRC_MODE_SYNC && (o_slot_active || slot_start))
      || (state == DRC_WAIT && can_start);

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   sync_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
      mode == DRC_MODE_SYNC && !o_slot_refresh_n |-> o_mem_hold)
      else $error("memory not held during sync slot refresh");
   async_free_a: assert property (@(posedge i_clk) disable iff (i_reset)
      mode == DRC_MODE_ASYNC && state == DRC_IDLE |-> !o_mem_hold)
      else $error("memory held after on-board refresh in async mode");
   decoup_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
      mode == DRC_MODE_DECOUP && dram_start |-> !i_mem_req)
      else $error("decoupled refresh started on busy bus");
   cbr_cas_a: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_dram.ras_n[0]) && !cbr_en |-> o_dram.cas_n)
      else $error("cas active in ras-only refresh");
   stagger_ras_a: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_dram.ras_n[0]) |-> o_dram.ras_n[3])
      else $error("banks not staggered");
   period_a: assert property (@(posedge i_clk) disable iff (i_reset)
      tick && !slow |=> !tick [*8])
      else $error("refresh tick too frequent");
   run_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state == DRC_RUN |-> o_mem_hold)
      else $error("on-board refresh did not hold memory");
   busy_wait_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state == DRC_WAIT && i_mem_busy |=> state != DRC_RUN)
      else $error("refresh started during memory cycle");
   slot_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
      slot_start |=> !o_slot_refresh_n [*8])
      else $error("slot refresh pulse too short");

endmodule
`default_nettype wire

// ---- verification/drc_mem_model.sv ----
/*
 Model of the memory requesters and DRAM banks beside the refresh controller.
 Assumes the controller's hold and row strobe outputs and one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module drc_mem_model
   import drc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_hold_busy,
   input wire logic i_want,
   input wire logic i_mem_hold,
   input wire drc_dram_s i_dram,
   output logic o_mem_busy,
   output logic o_mem_req,
   output logic [3:0] o_banks_seen
);
   // A requester opens a cycle only while memory is not held, then keeps it.
   always_ff @(posedge i_clk)
   begin
      if (i_reset || !i_hold_busy)
         o_mem_busy <= 1'b0;
      else if (!i_mem_hold)
         o_mem_busy <= 1'b1;
   end
   assign o_mem_req = i_want;
   // Banks that have seen a row strobe since reset.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_banks_seen <= 4'h0;
      else
         o_banks_seen <= o_banks_seen | ~i_dram.ras_n;
   end
endmodule
`default_nettype wire

// ---- verification/drc_refresh_tb.sv ----
/*
 Self-checking bench for the refresh controller.
 Assumes the register map macros and a partner model of the memory side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "drc_map.svh"
module drc_refresh_tb;
   import drc_pkg::*;
   logic i_clk, i_reset, hold_busy, want, mem_busy, mem_req, mem_hold, slot_n, slot_act;
   drc_bus_s bus;
   logic [15:0] rdata;
   logic [3:0] seen;
   drc_dram_s dram;
   int n_fail = 0;
   int n_tests = 0;
   int timer = 0;
   time t0;
   drc_refresh dut(.i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
      .i_mem_busy(mem_busy), .i_mem_req(mem_req), .o_mem_hold(mem_hold), .o_dram(dram),
      .o_slot_refresh_n(slot_n), .o_slot_active(slot_act));
   drc_mem_model partner(.i_clk(i_clk), .i_reset(i_reset), .i_hold_busy(hold_busy),
      .i_want(want), .i_mem_hold(mem_hold), .i_dram(dram), .o_mem_busy(mem_busy),
      .o_mem_req(mem_req), .o_banks_seen(seen));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task stop_test;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge i_clk)
   begin
      timer <= timer + 1;
      if (timer == 60000)
      begin
         n_fail++;
         stop_test();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk) bus <= '0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge i_clk) bus <= '0;
      #1 chk(rdata, exp);
   endtask
   // Waits for the watched strobe to be high and then low; 0 is bank 0, 1 the slot.
   task wait_low(input int sel, input int bound);
      int n;
      n = 0;
      while ((sel ? slot_n : dram.ras_n[0]) === 1'b0 && n < bound)
      begin
         @(posedge i_clk) #1 n++;
      end
      while ((sel ? slot_n : dram.ras_n[0]) !== 1'b0 && n < bound)
      begin
         @(posedge i_clk) #1 n++;
      end
      chk(16'(n < bound), 16'h0001);
   endtask
   // ----------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------
   initial
   begin
      bus = '0;
      i_reset = 1'b1;
      hold_busy = 1'b0;
      want = 1'b0;
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      rd(`DRC_REG_CTRL, `DRC_CTRL_RESET);
      rd(`DRC_REG_SLOTDIV, `DRC_SLOTDIV_RESET);
      rd(4'hC, 16'h0000);
      chk(mem_hold, 1'b0);
      wait_low(0, 1700);
      t0 = $time;
      chk(dram.ras_n, 4'hE);
      chk(mem_hold, 1'b1);
      chk(slot_n, 1'b0);
      chk(slot_act, 1'b1);
      @(posedge i_clk) #1 chk(dram.ras_n, 4'hC);
      wait_low(0, 1700);
      chk(16'(($time - t0) / 10), 16'(`DRC_STD_CYC));
      hold_busy <= 1'b1;
      repeat (1700) @(posedge i_clk);
      #1 chk(dram.ras_n, 4'hF);
      // Both requests stay pending while the sequencer waits for the memory cycle.
      rd(`DRC_REG_STAT, 16'h0019);
      hold_busy <= 1'b0;
      wait_low(0, 20);
      wr(`DRC_REG_CTRL, 16'h0015);
      wait_low(0, 1700);
      chk(dram.cas_n, 1'b0);
      repeat (7) @(posedge i_clk);
      #1 chk(dram.ras_n, 4'hF);
      chk(mem_hold, 1'b0);
      chk(slot_n, 1'b0);
      wr(`DRC_REG_SLOTDIV, 16'h0064);
      rd(`DRC_REG_SLOTDIV, 16'h0064);
      @(posedge i_clk) want <= 1'b1;
      wr(`DRC_REG_CTRL, 16'h0012);
      wait_low(1, 300);
      repeat (1700) @(posedge i_clk);
      #1 chk(dram.ras_n, 4'hF);
      @(posedge i_clk) want <= 1'b0;
      wait_low(0, 20);
      wr(`DRC_REG_CTRL, 16'h0018);
      wait_low(0, 13000);
      t0 = $time;
      wait_low(0, 13000);
      chk(16'(($time - t0) / 10), 16'(`DRC_SLOW_CYC));
      chk(16'(seen), 16'h000F);
      stop_test();
   end
endmodule
`default_nettype wire
